// ### hdl/svi_unit.sv
module svi_unit
   import svi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   output logic [7:0] o_rd_data,
   input wire logic [SVI_FLAG_N-1:0] i_src_event,
   input wire logic [SVI_FLAG_N-1:0] i_src_enable,
   input wire logic [2:0] i_stop_wake_raw,
   input wire logic [2:0] i_stop_wake_en,
   input wire logic i_reset_pin_b,
   input wire logic [13:0] i_cpu_next_pc,
   input wire logic [1:0] i_cpu_ccr,
   input wire logic i_instr_done,
   input wire logic i_exec_wait,
   input wire logic i_exec_stop,
   output logic o_irq_req,
   output logic o_vector_take,
   output logic [13:0] o_vector_addr,
   output logic o_resume,
   output logic o_sys_reset,
   output logic [13:0] o_reset_vector,
   output logic o_cpu_clk_halt,
   output logic o_module_clk_halt,
   output logic [13:0] o_return_pc,
   output logic [1:0] o_restore_ccr
);

   typedef struct packed {
      svi_mode_e mode;
      logic mask;
      logic stop_permission_bit;
      logic [1:0] holdoff;
      logic [7:0] ret_high;
      logic [7:0] ret_low;
      logic [7:0] rdata;
      logic vec_take;
      logic resume;
      logic sys_reset;
   } svi_ctl_s;

   localparam svi_ctl_s SVI_CTL_RST = '{
      mode: SVI_RUN,
      mask: SVI_MASK_RST,
      stop_permission_bit: SVI_STOP_PERMISSION_BIT_RST,
      holdoff: 2'h0,
      ret_high: 8'h00,
      ret_low: 8'h00,
      rdata: 8'h00,
      vec_take: 1'b0,
      resume: 1'b0,
      sys_reset: 1'b0
   };

   svi_ctl_s st;
   svi_ctl_s next_st;
   svi_link_if #(.N(SVI_FLAG_N), .W(SVI_WK_N)) link ();

   logic any_pend;
   logic mask_clr_wr;
   logic stop_wake;
   logic reset_pin_hit;

   // Condition codes ride in the two top bits of the high return byte.
   function automatic logic [15:0] svi_pack_ret(input logic [1:0] condition_code_bits, input logic [13:0] pc);
      svi_pack_ret = {condition_code_bits, pc};
   endfunction

   // Software clear strobes go straight to the flag latch as one-to-clear masks.
   always_comb begin
      link.clear = '0;
      if (i_wr_en && i_addr == SVI_OFF_CLR_ONE) begin
         link.clear[SVI_ONE_N-1:0] = i_wr_data;
      end
      if (i_wr_en && i_addr == SVI_OFF_CLR_TWO) begin
         link.clear[SVI_FLAG_N-1:SVI_ONE_N] = i_wr_data[SVI_FLAG_N-SVI_ONE_N-1:0];
      end
   end

   assign link.src_event = i_src_event;
   assign link.src_enable = i_src_enable;
   // The reset pin shares the synchroniser; it is inverted so a high lane means asserted.
   assign link.wake_raw = {~i_reset_pin_b, i_stop_wake_raw};

   svi_pend_latch #(.N(SVI_FLAG_N)) u_pend (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .bus(link.pend)
   );

   svi_wake_sync #(.W(SVI_WK_N)) u_wake (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .bus(link.wake)
   );

   // Decoded events used by the sequencer below.
   assign any_pend = |link.flags;
   assign mask_clr_wr = i_wr_en && i_addr == SVI_OFF_PEND_TWO && !i_wr_data[SVI_MASK_BIT];
   assign stop_wake = |(link.wake_sync[SVI_WK_PERIODIC:SVI_WK_KEYPAD] & i_stop_wake_en);
   assign reset_pin_hit = link.wake_sync[SVI_WK_RESET_PIN];

   // The request is a handshake term, so it is combinational from registered state.
   assign o_irq_req = st.mode == SVI_RUN && any_pend && !st.mask && st.holdoff == 2'h0;

   // Register port, mode sequencer and vectoring in one next-state block.
   // Hardware updates of the mask and return address win over a software write in the same cycle.
   always_comb begin
      next_st = st;
      next_st.vec_take = 1'b0;
      next_st.resume = 1'b0;
      next_st.sys_reset = 1'b0;
      next_st.rdata = 8'h00;
      if (st.holdoff != 2'h0) begin
         next_st.holdoff = st.holdoff - 2'h1;
      end

      if (i_wr_en) begin
         unique case (i_addr)
            SVI_OFF_PEND_TWO: begin
               next_st.mask = i_wr_data[SVI_MASK_BIT];
               if (mask_clr_wr) begin
                  next_st.holdoff = SVI_HOLDOFF_CYC;
               end
            end
            SVI_OFF_SYS_OPT: next_st.stop_permission_bit = i_wr_data[SVI_STOP_PERMISSION_BIT_BIT];
            SVI_OFF_RET_HIGH: next_st.ret_high = i_wr_data;
            SVI_OFF_RET_LOW: next_st.ret_low = i_wr_data;
            default: next_st.stop_permission_bit = st.stop_permission_bit;
         endcase
      end

      if (i_rd_en) begin
         unique case (i_addr)
            SVI_OFF_PEND_ONE: next_st.rdata = link.flags[SVI_ONE_N-1:0];
            SVI_OFF_PEND_TWO: next_st.rdata = {st.mask, link.flags[SVI_FLAG_N-1:SVI_ONE_N]};
            SVI_OFF_SYS_OPT: next_st.rdata = {7'h00, st.stop_permission_bit};
            SVI_OFF_EXIT_JUMP: next_st.rdata = SVI_JMP_OPCODE;
            SVI_OFF_RET_HIGH: next_st.rdata = st.ret_high;
            SVI_OFF_RET_LOW: next_st.rdata = st.ret_low;
            SVI_OFF_STATUS: next_st.rdata = {6'h00, st.mode};
            default: next_st.rdata = 8'h00;
         endcase
      end

      // Only the program counter and condition codes are captured; the accumulator
      // and index stay with software, which keeps this block small.
      unique case (st.mode)
         SVI_RUN: begin
            if (o_irq_req && i_instr_done) begin
               {next_st.ret_high, next_st.ret_low} = svi_pack_ret(i_cpu_ccr, i_cpu_next_pc);
               next_st.mask = 1'b1;
               next_st.vec_take = 1'b1;
            end else if (i_exec_wait) begin
               next_st.mode = SVI_WAIT;
            end else if (i_exec_stop) begin
               if (st.stop_permission_bit) begin
                  next_st.mode = SVI_STOP;
               end else begin
                  next_st.sys_reset = 1'b1;
               end
            end
         end
         SVI_WAIT: begin
            if (link.new_flag) begin
               next_st.mode = SVI_RUN;
               if (st.mask) begin
                  next_st.resume = 1'b1;
               end else begin
                  {next_st.ret_high, next_st.ret_low} = svi_pack_ret(i_cpu_ccr, i_cpu_next_pc);
                  next_st.mask = 1'b1;
                  next_st.vec_take = 1'b1;
               end
            end
         end
         SVI_STOP: begin
            if (reset_pin_hit) begin
               next_st.mode = SVI_RUN;
               next_st.sys_reset = 1'b1;
            end else if (stop_wake) begin
               next_st.mode = SVI_RUN;
               if (st.mask) begin
                  next_st.resume = 1'b1;
               end else begin
                  {next_st.ret_high, next_st.ret_low} = svi_pack_ret(i_cpu_ccr, i_cpu_next_pc);
                  next_st.mask = 1'b1;
                  next_st.vec_take = 1'b1;
               end
            end
         end
         default: begin
            next_st.mode = SVI_RUN;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= SVI_CTL_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from the state register or constants.
   // The exit jump returns through these; the CPU restores the codes on that jump.
   assign o_rd_data = st.rdata;
   assign o_vector_take = st.vec_take;
   assign o_vector_addr = SVI_VECTOR_ADDR;
   assign o_resume = st.resume;
   assign o_sys_reset = st.sys_reset;
   assign o_reset_vector = SVI_RESET_VECTOR;
   assign o_cpu_clk_halt = st.mode != SVI_RUN;
   assign o_module_clk_halt = st.mode == SVI_STOP;
   assign o_return_pc = {st.ret_high[5:0], st.ret_low};
   assign o_restore_ccr = st.ret_high[7:6];

   a_vec_sets_mask: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.vec_take |-> st.mask && st.mode == SVI_RUN)
      else $error("vectoring without mask set");

   a_req_vectors: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_irq_req && i_instr_done |=> st.vec_take && o_vector_addr == SVI_VECTOR_ADDR)
      else $error("pending request not vectored");

   a_masked_no_vec: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode == SVI_RUN && st.mask && !(i_wr_en && i_addr == SVI_OFF_PEND_TWO) |-> ##1 !st.vec_take)
      else $error("vectored while masked");

   a_holdoff_three: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      mask_clr_wr && !(o_irq_req && i_instr_done) |=> !o_irq_req [*3])
      else $error("request within holdoff");

   a_ret_saved: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_irq_req && i_instr_done |=> o_return_pc == $past(i_cpu_next_pc) && o_restore_ccr == $past(i_cpu_ccr))
      else $error("return address or codes not saved");

   a_wait_resume: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode == SVI_WAIT && st.mask && link.new_flag |=> o_resume && !o_vector_take && !o_cpu_clk_halt)
      else $error("masked wait wake wrong");

   a_wait_vector: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode == SVI_WAIT && !st.mask && link.new_flag |=> o_vector_take && o_return_pc == $past(i_cpu_next_pc))
      else $error("unmasked wait wake wrong");

   a_stop_illegal: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode == SVI_RUN && !o_irq_req && !i_exec_wait && i_exec_stop && !st.stop_permission_bit
      |=> o_sys_reset && !o_module_clk_halt)
      else $error("stop without permission not reset");

   a_stop_reset_pin: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode == SVI_STOP && reset_pin_hit |=> o_sys_reset && st.mode == SVI_RUN)
      else $error("reset pin did not end stop");

   a_stop_wake: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode == SVI_STOP && !reset_pin_hit && stop_wake |=> (o_resume != o_vector_take) && !o_cpu_clk_halt)
      else $error("stop wake wrong");

   a_exit_opcode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      i_rd_en && i_addr == SVI_OFF_EXIT_JUMP |=> o_rd_data == SVI_JMP_OPCODE)
      else $error("exit jump opcode not read");

   // Mode entry, holding and release checks watch the sequencer from its ports and state.
   // They guard against a sleep mode that leaks out early, which software could never see by polling.
   a_wait_enter: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode == SVI_RUN && i_exec_wait && !(o_irq_req && i_instr_done) |=> st.mode == SVI_WAIT && o_cpu_clk_halt)
      else $error("wait not entered");

   a_wait_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode == SVI_WAIT && !link.new_flag |=> st.mode == SVI_WAIT && !o_resume && !o_vector_take)
      else $error("wait left without a new flag");

   a_stop_enter: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode == SVI_RUN && !(o_irq_req && i_instr_done) && !i_exec_wait && i_exec_stop && st.stop_permission_bit
      |=> st.mode == SVI_STOP && o_module_clk_halt && !o_sys_reset)
      else $error("permitted stop not entered");

   a_stop_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode == SVI_STOP && !stop_wake && !reset_pin_hit |=> st.mode == SVI_STOP && !o_resume && !o_vector_take)
      else $error("stop left without an enabled wake");

   a_flag_gated: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      |(i_src_event & ~i_src_enable) |=> (link.flags & ~$past(link.flags) & ~$past(i_src_enable)) == '0)
      else $error("flag set for a disabled source");

   a_vec_keeps_flags: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_irq_req && i_instr_done && link.clear == '0 |=> (link.flags & $past(link.flags)) == $past(link.flags))
      else $error("vectoring cleared a pending flag");

   a_vec_one_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_vector_take |=> !o_vector_take)
      else $error("vector pulse longer than one cycle");

   a_wake_exclusive: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_resume |-> !o_vector_take)
      else $error("resume and vector together");

   a_holdoff_bound: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      mask_clr_wr ##1 (!mask_clr_wr) [*3] |=> st.holdoff == 2'h0)
      else $error("holdoff longer than three cycles");

   a_reset_only_stop: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode != SVI_STOP && !(st.mode == SVI_RUN && i_exec_stop) |=> !o_sys_reset)
      else $error("reset request outside stop");

   a_ret_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !next_st.vec_take && !(i_wr_en && (i_addr == SVI_OFF_RET_HIGH || i_addr == SVI_OFF_RET_LOW))
      |=> $stable(o_return_pc) && $stable(o_restore_ccr))
      else $error("return address changed unprompted");

   a_masked_wait_no_vec: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st.mode == SVI_WAIT && st.mask |=> !o_vector_take)
      else $error("masked wait vectored");

endmodule // svi_unit

// ### hdl/svi_pkg.sv
package svi_pkg;

   // Register offsets on the local 4-bit register port.
   localparam logic [3:0] SVI_OFF_PEND_ONE = 4'h0;
   localparam logic [3:0] SVI_OFF_PEND_TWO = 4'h1;
   localparam logic [3:0] SVI_OFF_CLR_ONE = 4'h2;
   localparam logic [3:0] SVI_OFF_CLR_TWO = 4'h3;
   localparam logic [3:0] SVI_OFF_SYS_OPT = 4'h4;
   localparam logic [3:0] SVI_OFF_EXIT_JUMP = 4'h5;
   localparam logic [3:0] SVI_OFF_RET_HIGH = 4'h6;
   localparam logic [3:0] SVI_OFF_RET_LOW = 4'h7;
   localparam logic [3:0] SVI_OFF_STATUS = 4'h8;

   // Field positions.
   localparam int unsigned SVI_MASK_BIT = 7;
   localparam int unsigned SVI_STOP_PERMISSION_BIT_BIT = 0;
   localparam int unsigned SVI_FLAG_N = 15;
   localparam int unsigned SVI_ONE_N = 8;

   // Reset values.
   localparam logic SVI_MASK_RST = 1'b1;
   localparam logic SVI_STOP_PERMISSION_BIT_RST = 1'b0;

   // Fixed addresses and the hardware-encoded jump opcode.
   localparam logic [13:0] SVI_VECTOR_ADDR = 14'h3ff7;
   localparam logic [13:0] SVI_RESET_VECTOR = 14'h3ffd;
   localparam logic [7:0] SVI_JMP_OPCODE = 8'hbc;

   // Cycles during which vectoring stays held off after the mask is cleared.
   localparam logic [1:0] SVI_HOLDOFF_CYC = 2'h3;

   // Stop-mode wake sources and the reset pin, as synchroniser lanes.
   localparam int unsigned SVI_WK_KEYPAD = 0;
   localparam int unsigned SVI_WK_COMPARATOR = 1;
   localparam int unsigned SVI_WK_PERIODIC = 2;
   localparam int unsigned SVI_WK_RESET_PIN = 3;
   localparam int unsigned SVI_WK_N = 4;

   typedef enum logic [1:0] {
      SVI_RUN = 2'b00,
      SVI_WAIT = 2'b01,
      SVI_STOP = 2'b10
   } svi_mode_e;

endpackage : svi_pkg

// ### hdl/svi_link_if.sv
interface svi_link_if #(
   parameter int unsigned N = 15,
   parameter int unsigned W = 4
);
   logic [N-1:0] src_event;
   logic [N-1:0] src_enable;
   logic [N-1:0] clear;
   logic [N-1:0] flags;
   logic new_flag;
   logic [W-1:0] wake_raw;
   logic [W-1:0] wake_sync;

   modport pend (input src_event, input src_enable, input clear, output flags, output new_flag);
   modport wake (input wake_raw, output wake_sync);
   modport ctrl (output src_event, output src_enable, output clear, output wake_raw,
                 input flags, input new_flag, input wake_sync);
endinterface : svi_link_if

// ### hdl/svi_pend_latch.sv
module svi_pend_latch #(
   parameter int unsigned N = 15
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   svi_link_if.pend bus
);
   typedef struct packed {
      logic [N-1:0] flags;
      logic new_flag;
   } svi_pend_s;

   svi_pend_s st;
   svi_pend_s next_st;

   // A flag only sets for an enabled source, and a set arriving with a clear wins.
   always_comb begin
      next_st = st;
      next_st.flags = (st.flags & ~bus.clear) | (bus.src_event & bus.src_enable);
      next_st.new_flag = |(bus.src_event & bus.src_enable & ~st.flags);
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign bus.flags = st.flags;
   assign bus.new_flag = st.new_flag;

endmodule // svi_pend_latch

// ### hdl/svi_wake_sync.sv
module svi_wake_sync #(
   parameter int unsigned W = 4
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   svi_link_if.wake bus
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } svi_sync_s;

   svi_sync_s st;
   svi_sync_s next_st;

   // Two flops per lane; the first stage is read by the second only.
   always_comb begin
      next_st.meta = bus.wake_raw;
      next_st.sync = st.meta;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign bus.wake_sync = st.sync;

endmodule // svi_wake_sync

// ### bench/svi_cpu_model.sv
module svi_cpu_model
   import svi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_step,
   input wire logic i_halt,
   input wire logic i_vector_take,
   output logic [13:0] o_next_pc,
   output logic [1:0] o_ccr,
   output logic o_instr_done
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [13:0] pc;

   // A stopped core retires nothing, so no boundary is reported while its clock is halted.
   assign o_instr_done = i_step & ~i_halt;
   assign o_next_pc = pc;
   // The flags are the inverse of the low address bits, so a swapped field cannot pass.
   assign o_ccr = ~pc[1:0];

   // The vector slot holds the jump opcode and a two-byte routine address, so the core lands there.
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pc <= 14'h0100;
      end else if (i_vector_take) begin
         pc <= SVI_VECTOR_ADDR;
      end else if (o_instr_done) begin
         pc <= pc + 14'h0001;
      end
   end
endmodule // svi_cpu_model

// ### bench/tb_svi_unit.sv
module tb_svi_unit
   import svi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, pin_b = 1'b1, step = 1'b0;
   logic ex_wait = 1'b0, ex_stop = 1'b0, done, irq, vtake, resume, sreset, chalt, mhalt;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rd_data;
   logic [14:0] ev = 15'h0000, en = 15'h0000;
   logic [2:0] wake_raw = 3'h0, wake_en = 3'h3;
   logic [13:0] next_pc, vaddr, rvec, rpc, pcv;
   logic [1:0] condition_code_bits, rccr, ccv;
   int mismatches = 0, check_count = 0, n_vec = 0, n_res = 0, n_rst = 0;

   svi_unit svi_unit_i (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .o_rd_data(rd_data), .i_src_event(ev), .i_src_enable(en), .i_stop_wake_raw(wake_raw),
      .i_stop_wake_en(wake_en), .i_reset_pin_b(pin_b), .i_cpu_next_pc(next_pc), .i_cpu_ccr(condition_code_bits),
      .i_instr_done(done), .i_exec_wait(ex_wait), .i_exec_stop(ex_stop), .o_irq_req(irq),
      .o_vector_take(vtake), .o_vector_addr(vaddr), .o_resume(resume), .o_sys_reset(sreset),
      .o_reset_vector(rvec), .o_cpu_clk_halt(chalt), .o_module_clk_halt(mhalt), .o_return_pc(rpc),
      .o_restore_ccr(rccr));

   svi_cpu_model svi_cpu_model_i (.i_clk(clk), .i_rst_b(rst_b), .i_step(step), .i_halt(chalt),
      .i_vector_take(vtake), .o_next_pc(next_pc), .o_ccr(condition_code_bits), .o_instr_done(done));

   // Half period of the 25 MHz clock.
   always #20 clk = ~clk;

   // One-cycle pulses are tallied, so a doubled or missing pulse shows in the totals.
   always @(posedge clk) begin
      if (vtake === 1'b1) n_vec++;
      if (resume === 1'b1) n_res++;
      if (sreset === 1'b1) n_rst++;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // Read data stand only in the cycle after the read edge, so they are sampled there.
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(16'(rd_data), 16'(exp));
   endtask

   // Kind 0 retires one instruction, 1 executes wait, 2 executes stop.
   task automatic pulse(input int k);
      @(posedge clk);
      step <= (k == 0);
      ex_wait <= (k == 1);
      ex_stop <= (k == 2);
      @(posedge clk);
      step <= 1'b0;
      ex_wait <= 1'b0;
      ex_stop <= 1'b0;
      #1;
   endtask

   task automatic fire(input logic [14:0] b);
      @(posedge clk);
      ev <= b;
      @(posedge clk);
      ev <= 15'h0000;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic set_wake(input logic [2:0] w);
      @(posedge clk);
      wake_raw <= w;
   endtask

   task automatic report_and_stop;
      $display("Comparisons: %0d, mismatches: %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // The whole sequence needs well under a thousand cycles; this bound only catches a hang.
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd(SVI_OFF_PEND_TWO, 8'h80);
      rd(SVI_OFF_SYS_OPT, 8'h00);
      rd(SVI_OFF_EXIT_JUMP, SVI_JMP_OPCODE);
      rd(4'hf, 8'h00);
      chk(16'(vaddr), 16'(SVI_VECTOR_ADDR));
      chk(16'(rvec), 16'(SVI_RESET_VECTOR));
      fire(15'h0201);
      rd(SVI_OFF_PEND_ONE, 8'h00);
      @(posedge clk);
      en <= 15'h7fff;
      fire(15'h0201);
      rd(SVI_OFF_PEND_ONE, 8'h01);
      rd(SVI_OFF_PEND_TWO, 8'h82);
      pulse(0);
      idle(2);
      chk(16'(irq), 16'h0);
      chk(16'(n_vec), 16'd0);
      // Clearing the mask with flags pending must still hold the request off for three cycles.
      wr(SVI_OFF_PEND_TWO, 8'h00);
      for (int i = 0; i < 4; i++) begin
         #1;
         chk(16'(irq), 16'(i == 3));
         @(posedge clk);
      end
      #1;
      pcv = next_pc;
      ccv = condition_code_bits;
      pulse(0);
      chk(16'(vtake), 16'h1);
      chk(16'(irq), 16'h0);
      chk(16'(rpc), 16'(pcv));
      chk(16'(rccr), 16'(ccv));
      rd(SVI_OFF_RET_HIGH, {ccv, pcv[13:8]});
      rd(SVI_OFF_RET_LOW, pcv[7:0]);
      rd(SVI_OFF_PEND_TWO, 8'h82);
      chk(16'(n_vec), 16'd1);
      // Flags survive vectoring until software writes ones to them.
      rd(SVI_OFF_PEND_ONE, 8'h01);
      wr(SVI_OFF_CLR_ONE, 8'h01);
      wr(SVI_OFF_CLR_TWO, 8'h02);
      rd(SVI_OFF_PEND_ONE, 8'h00);
      wr(SVI_OFF_RET_HIGH, 8'hc5);
      wr(SVI_OFF_RET_LOW, 8'h3a);
      idle(1);
      chk(16'(rpc), 16'h053a);
      chk(16'(rccr), 16'h3);
      rd(SVI_OFF_PEND_TWO, 8'h80);
      // Wait with the mask set wakes without vectoring.
      pulse(1);
      chk(16'(chalt), 16'h1);
      rd(SVI_OFF_STATUS, 8'h01);
      fire(15'h0004);
      idle(5);
      chk(16'(n_res), 16'd1);
      chk(16'(n_vec), 16'd1);
      chk(16'(chalt), 16'h0);
      wr(SVI_OFF_CLR_ONE, 8'h04);
      wr(SVI_OFF_PEND_TWO, 8'h00);
      idle(4);
      pulse(1);
      pcv = next_pc;
      ccv = condition_code_bits;
      fire(15'h4000);
      idle(5);
      chk(16'(n_vec), 16'd2);
      chk(16'(rpc), 16'(pcv));
      chk(16'(rccr), 16'(ccv));
      rd(SVI_OFF_PEND_TWO, 8'hc0);
      wr(SVI_OFF_CLR_TWO, 8'h40);
      // Stop without permission must request a reset and stay running.
      pulse(2);
      idle(2);
      chk(16'(n_rst), 16'd1);
      rd(SVI_OFF_STATUS, 8'h00);
      wr(SVI_OFF_SYS_OPT, 8'h01);
      pulse(2);
      chk(16'({chalt, mhalt}), 16'h3);
      rd(SVI_OFF_STATUS, 8'h02);
      // A plain flag and a disabled stop source must leave the device stopped.
      fire(15'h0008);
      set_wake(3'b100);
      idle(6);
      rd(SVI_OFF_STATUS, 8'h02);
      wr(SVI_OFF_CLR_ONE, 8'h08);
      set_wake(3'b101);
      idle(6);
      chk(16'(n_res), 16'd2);
      rd(SVI_OFF_STATUS, 8'h00);
      set_wake(3'b000);
      wr(SVI_OFF_PEND_TWO, 8'h00);
      pulse(2);
      pcv = next_pc;
      set_wake(3'b010);
      idle(6);
      chk(16'(n_vec), 16'd3);
      chk(16'(rpc), 16'(pcv));
      rd(SVI_OFF_PEND_TWO, 8'h80);
      set_wake(3'b000);
      pulse(2);
      @(posedge clk);
      pin_b <= 1'b0;
      idle(6);
      chk(16'(n_rst), 16'd2);
      rd(SVI_OFF_STATUS, 8'h00);
      @(posedge clk);
      pin_b <= 1'b1;
      idle(4);
      report_and_stop();
   end
endmodule // tb_svi_unit
